// ---- design/sync_ctrl_consts.svh ----
// Constants for the sync processor control and blanking block.
// What this block does
// - Respond only to fixed address, write bit clear.
// - Mode bit 0 high selects standard mode.
// - Mode bit 1 low selects external video.
// - Mode bit 2 low activates non-interlace request.
// - Bit 3 chooses which test bits are ignored.
// - Non-interlace shortens vertical flyback by 32 us.
// - Noise only in standard forces nominal, 625.
// - Lock: gating on, slow, mute low, indirect.
// - No lock: gating off, fast, mute high, direct.
// - 50 Hz direct blanking: 16 us late, 22.5 lines.
// - 50 Hz indirect: early 2.5 lines plus 20 us.
// - 60 Hz direct blanking: 16 us late, 18.5 lines.
// - 60 Hz indirect: at sync, 18.5 lines long.
// - Ident output low at 50 Hz or when 625 is forced, high 60.
// - Mute high unsynchronised, low when synchronised.
`ifndef SYNC_CTRL_CONSTS_SVH
`define SYNC_CTRL_CONSTS_SVH

// ==========================================================================
// Serial link
// ==========================================================================
`define SC_SLAVE_ADDR     8'h8c
`define SC_MODE_RESET     8'hff
// Control word at reset: standard mode and mute set, matching the reset mode byte.
`define SC_CTL_RESET      14'h0201
`define SC_BIT_STD        0
`define SC_BIT_EXTV       1
`define SC_BIT_NIL        2
`define SC_BIT_TSEL       3
`define SC_BIT_T4         4
`define SC_BIT_T5         5
`define SC_BIT_T6         6
`define SC_BIT_T7         7

// ==========================================================================
// Timing, clock 200 MHz
// ==========================================================================
`define SC_CLK_MHZ        200
`define SC_LINE_NS        64000
`define SC_LINE_CYC       ((`SC_LINE_NS * `SC_CLK_MHZ) / 1000)
`define SC_HALF_LINE_CYC  (`SC_LINE_CYC / 2)
`define SC_DIRECT_US      16
`define SC_DIRECT_CYC     (`SC_DIRECT_US * `SC_CLK_MHZ)
`define SC_IND50_US       20
`define SC_IND50_CYC      (`SC_IND50_US * `SC_CLK_MHZ)
`define SC_IND50_EXTRA_US 2
`define SC_IND50_EXTRA_CYC (`SC_IND50_EXTRA_US * `SC_CLK_MHZ)
`define SC_NIL_SHORT_US   32
`define SC_NIL_SHORT_CYC  (`SC_NIL_SHORT_US * `SC_CLK_MHZ)
`define SC_FLYBACK_US     220
`define SC_FLYBACK_CYC    (`SC_FLYBACK_US * `SC_CLK_MHZ)
// Blanking lengths in half lines: 22.5, 25, 18.5 lines, and 2.5 lines lead.
`define SC_HL_50_DIRECT   45
`define SC_HL_50_INDIRECT 50
`define SC_HL_60          37
`define SC_HL_50_LEAD     5
`define SC_FIELD_LINES    625

`endif

// ---- design/sync_ctrl_pkg.sv ----
// Package with the state types of the sync processor control block.
package sync_ctrl_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_SKIP} link_state_e;
  typedef enum logic [1:0] {BK_IDLE, BK_WAIT, BK_ON} blank_state_e;
endpackage

// ---- design/mode_link_slave.sv ----
// Two-wire write-only slave that receives the address and the mode byte.
`timescale 1ns/1ps
`include "sync_ctrl_consts.svh"
module mode_link_slave
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  output logic [7:0]      o_mode_q,
  output logic            o_mode_stb
);
  // ==========================================================================
  // Link state
  // ==========================================================================
  sync_ctrl_pkg::link_state_e st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic       scl_q, sda_q, oe_q, oe_d, stb_d;
  logic [7:0] mode_d;
  logic       rise, fall, start, stop;

  assign rise  = i_scl & ~scl_q;
  assign fall  = ~i_scl & scl_q;
  assign start = i_scl & scl_q & sda_q & ~i_sda;
  assign stop  = i_scl & scl_q & ~sda_q & i_sda;

  // Next state for the byte receiver and the acknowledge driver.
  always_comb
  begin
    st_d   = st_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    oe_d   = oe_q;
    mode_d = o_mode_q;
    stb_d  = 1'b0;
    if (start)
    begin
      st_d  = sync_ctrl_pkg::ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end
    else if (stop)
    begin
      st_d = sync_ctrl_pkg::ST_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        sync_ctrl_pkg::ST_ADDR, sync_ctrl_pkg::ST_DATA:
        begin
          if (rise)
          begin
            sh_d  = {sh_q[6:0], i_sda};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == 4'h8)
          begin
            cnt_d = 4'h0;
            if (st_q == sync_ctrl_pkg::ST_DATA)
            begin
              oe_d = 1'b1;
              st_d = sync_ctrl_pkg::ST_DATA_ACK;
            end
            else if (sh_q == `SC_SLAVE_ADDR)
            begin
              oe_d = 1'b1;
              st_d = sync_ctrl_pkg::ST_ADDR_ACK;
            end
            else
              st_d = sync_ctrl_pkg::ST_SKIP;
          end
        end
        sync_ctrl_pkg::ST_ADDR_ACK:
          if (fall)
          begin
            oe_d = 1'b0;
            st_d = sync_ctrl_pkg::ST_DATA;
          end
        sync_ctrl_pkg::ST_DATA_ACK:
          if (fall)
          begin
            oe_d   = 1'b0;
            mode_d = sh_q;
            stb_d  = 1'b1;
            st_d   = sync_ctrl_pkg::ST_SKIP;
          end
        sync_ctrl_pkg::ST_SKIP, sync_ctrl_pkg::ST_IDLE:
          st_d = st_q;
        default:
          st_d = sync_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // Registers of the link receiver.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      st_q       <= sync_ctrl_pkg::ST_IDLE;
      sh_q       <= 8'h00;
      cnt_q      <= 4'h0;
      oe_q       <= 1'b0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      o_mode_q   <= `SC_MODE_RESET;
      o_mode_stb <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      sh_q       <= sh_d;
      cnt_q      <= cnt_d;
      oe_q       <= oe_d;
      scl_q      <= i_scl;
      sda_q      <= i_sda;
      o_mode_q   <= mode_d;
      o_mode_stb <= stb_d;
    end
  end

  assign o_sda_oe = oe_q;
endmodule // mode_link_slave

// ---- design/sync_ctrl.sv ----
// Top of the sync processor control: mode decode, lock switching, blanking.
`timescale 1ns/1ps
`include "sync_ctrl_consts.svh"
module sync_ctrl
#(
  parameter int LINE_CYC    = `SC_LINE_CYC,
  parameter int FLYBACK_CYC = `SC_FLYBACK_CYC
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  input  wire logic i_coinc_lock,
  input  wire logic i_noise_only,
  input  wire logic i_field_60hz,
  input  wire logic i_vsync_start,
  output logic      o_standard_mode,
  output logic      o_external_video_select,
  output logic      o_nil_active,
  output logic      o_test_mode,
  output logic      o_force_nominal,
  output logic      o_force_625,
  output logic      o_phase1_gate,
  output logic      o_slow_discr,
  output logic      o_clamp_gate,
  output logic      o_mute,
  output logic      o_indirect_sync,
  output logic      o_hsep_gated,
  output logic      o_noise_inhibit,
  output logic      o_ident_60hz,
  output logic      o_vblank,
  output logic      o_vflyback
);
  // ==========================================================================
  // Mode byte reception
  // ==========================================================================
  logic [7:0] mode_q;

  mode_link_slave u_link
  (
    .i_sys_clk  (i_sys_clk),
    .i_reset_n  (i_reset_n),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (o_sda_oe),
    .o_mode_q   (mode_q),
    .o_mode_stb ()
  );

  // The acknowledge only ever pulls the data line low.
  assign o_sda_o = 1'b0;

  // ==========================================================================
  // Control outputs, registered
  // ==========================================================================
  logic [13:0] ctl_d, ctl_q;
  logic        std_d, test_d;

  // Decode of the mode byte and the lock dependent switches.
  always_comb
  begin
    std_d = mode_q[`SC_BIT_STD];
    // Test bits active low; bit 4 always counts, bit 3 masks bit 5 or bits 6 and 7.
    if (mode_q[`SC_BIT_TSEL])
      test_d = ~mode_q[`SC_BIT_T4] | ~mode_q[`SC_BIT_T6] | ~mode_q[`SC_BIT_T7];
    else
      test_d = ~mode_q[`SC_BIT_T4] | ~mode_q[`SC_BIT_T5];
    ctl_d[0]  = std_d;
    ctl_d[1]  = ~mode_q[`SC_BIT_EXTV];
    ctl_d[2]  = ~mode_q[`SC_BIT_NIL];
    ctl_d[3]  = test_d;
    ctl_d[4]  = std_d & i_noise_only;
    ctl_d[5]  = std_d & i_noise_only;
    ctl_d[6]  = i_coinc_lock;
    ctl_d[7]  = i_coinc_lock;
    ctl_d[8]  = i_coinc_lock;
    ctl_d[9]  = ~i_coinc_lock;
    ctl_d[10] = i_coinc_lock;
    ctl_d[11] = i_coinc_lock;
    ctl_d[12] = i_coinc_lock;
    ctl_d[13] = i_field_60hz & ~(std_d & i_noise_only);
  end

  // Control register.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      ctl_q <= `SC_CTL_RESET;
    else
      ctl_q <= ctl_d;
  end

  assign o_standard_mode         = ctl_q[0];
  assign o_external_video_select = ctl_q[1];
  assign o_nil_active            = ctl_q[2];
  assign o_test_mode             = ctl_q[3];
  assign o_force_nominal         = ctl_q[4];
  assign o_force_625             = ctl_q[5];
  assign o_phase1_gate           = ctl_q[6];
  assign o_slow_discr            = ctl_q[7];
  assign o_clamp_gate            = ctl_q[8];
  assign o_mute                  = ctl_q[9];
  assign o_indirect_sync         = ctl_q[10];
  assign o_hsep_gated            = ctl_q[11];
  assign o_noise_inhibit         = ctl_q[12];
  assign o_ident_60hz            = ctl_q[13];

  // ==========================================================================
  // Vertical blanking and flyback timing
  // ==========================================================================
  // Indirect 50 Hz blanking starts before sync, so it is started a whole
  // field earlier, counted in half lines from the previous sync start.
  localparam int HALF = LINE_CYC / 2;
  localparam int FIELD_HL = `SC_FIELD_LINES;
  localparam int LEAD_CYC = FIELD_HL * HALF - (`SC_HL_50_LEAD * HALF + `SC_IND50_CYC);

  sync_ctrl_pkg::blank_state_e bk_q, bk_d;
  logic [31:0] tmr_q, tmr_d, len_q, len_d, fb_q, fb_d;
  logic        blank_q, blank_d, fly_q, fly_d;
  logic        is60, ind;

  assign is60 = ctl_q[13];
  assign ind  = ctl_q[10];

  // Blanking placement and flyback timer.
  always_comb
  begin
    bk_d    = bk_q;
    tmr_d   = tmr_q;
    len_d   = len_q;
    blank_d = blank_q;
    fb_d    = fb_q;
    fly_d   = fly_q;
    case (bk_q)
      sync_ctrl_pkg::BK_IDLE:
        blank_d = 1'b0;
      sync_ctrl_pkg::BK_WAIT:
        if (tmr_q == 32'h0)
        begin
          bk_d    = sync_ctrl_pkg::BK_ON;
          blank_d = 1'b1;
          tmr_d   = len_q;
        end
        else
          tmr_d = tmr_q - 32'h1;
      sync_ctrl_pkg::BK_ON:
        if (tmr_q <= 32'h1)
        begin
          bk_d    = sync_ctrl_pkg::BK_IDLE;
          blank_d = 1'b0;
        end
        else
          tmr_d = tmr_q - 32'h1;
      default:
        bk_d = sync_ctrl_pkg::BK_IDLE;
    endcase
    if (i_vsync_start && bk_q != sync_ctrl_pkg::BK_ON)
    begin
      bk_d = sync_ctrl_pkg::BK_WAIT;
      if (!ind)
      begin
        tmr_d = 32'(`SC_DIRECT_CYC);
        len_d = is60 ? 32'(`SC_HL_60 * HALF - `SC_DIRECT_CYC)
                     : 32'(`SC_HL_50_DIRECT * HALF - `SC_DIRECT_CYC);
      end
      else if (is60)
      begin
        tmr_d   = 32'h0;
        len_d   = 32'(`SC_HL_60 * HALF);
      end
      else
      begin
        tmr_d = 32'(LEAD_CYC);
        len_d = 32'(`SC_HL_50_INDIRECT * HALF + `SC_IND50_EXTRA_CYC);
      end
    end
    // Flyback shortened by the non-interlace request.
    if (i_vsync_start)
    begin
      fly_d = 1'b1;
      fb_d  = ctl_q[2] ? 32'(FLYBACK_CYC - `SC_NIL_SHORT_CYC) : 32'(FLYBACK_CYC);
    end
    else if (fb_q > 32'h1)
      fb_d = fb_q - 32'h1;
    else
    begin
      fb_d  = 32'h0;
      fly_d = 1'b0;
    end
  end

  // Blanking registers.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      bk_q    <= sync_ctrl_pkg::BK_IDLE;
      tmr_q   <= 32'h0;
      len_q   <= 32'h0;
      blank_q <= 1'b0;
      fb_q    <= 32'h0;
      fly_q   <= 1'b0;
    end
    else
    begin
      bk_q    <= bk_d;
      tmr_q   <= tmr_d;
      len_q   <= len_d;
      blank_q <= blank_d;
      fb_q    <= fb_d;
      fly_q   <= fly_d;
    end
  end

  assign o_vblank   = blank_q;
  assign o_vflyback = fly_q;
endmodule // sync_ctrl

// ---- testbench/sync_ctrl_props.sv ----
// Concurrent checks on the ports of the sync control top.
`timescale 1ns/1ps
module sync_ctrl_props
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic i_coinc_lock,
  input wire logic i_noise_only,
  input wire logic i_field_60hz,
  input wire logic i_vsync_start,
  input wire logic o_standard_mode,
  input wire logic o_external_video_select,
  input wire logic o_nil_active,
  input wire logic o_force_nominal,
  input wire logic o_force_625,
  input wire logic o_phase1_gate,
  input wire logic o_slow_discr,
  input wire logic o_clamp_gate,
  input wire logic o_mute,
  input wire logic o_indirect_sync,
  input wire logic o_hsep_gated,
  input wire logic o_noise_inhibit,
  input wire logic o_ident_60hz,
  input wire logic o_vblank
);
  // ==========================================================================
  // Properties on the system clock, switched off while in reset.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_rst;
    !$past(i_reset_n) |-> o_standard_mode && !o_external_video_select && !o_nil_active && o_mute;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_mute;
    $past(i_reset_n) |-> o_mute == !$past(i_coinc_lock);
  endproperty
  a_mute: assert property (p_mute) else $error("mute wrong");
  property p_gate;
    $past(i_reset_n) |-> {o_phase1_gate, o_slow_discr, o_clamp_gate, o_indirect_sync, o_hsep_gated,
      o_noise_inhibit} == {6{$past(i_coinc_lock)}};
  endproperty
  a_gate: assert property (p_gate) else $error("lock switching wrong");
  property p_force;
    $past(i_reset_n) && $stable(o_standard_mode) |->
      o_force_625 == (o_standard_mode && $past(i_noise_only)) && o_force_nominal == o_force_625;
  endproperty
  a_force: assert property (p_force) else $error("noise fallback wrong");
  property p_ident;
    $past(i_reset_n) && !$past(i_noise_only) && !$past(i_noise_only, 2) |-> o_ident_60hz == $past(i_field_60hz);
  endproperty
  a_ident: assert property (p_ident) else $error("ident wrong");
  property p_mode;
    $changed({o_standard_mode, o_external_video_select, o_nil_active}) |-> !i_scl;
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed off ack");
  property p_ack;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack: assert property (p_ack) else $error("ack while clock high");
  property p_vb60;
    i_vsync_start && i_coinc_lock && $past(i_coinc_lock) && i_field_60hz && !i_noise_only |-> ##[1:3] o_vblank;
  endproperty
  a_vb60: assert property (p_vb60) else $error("indirect blank late");
endmodule // sync_ctrl_props

// ---- testbench/i2c_host_model.sv ----
// Two-wire bus master model that writes an address byte and a mode byte.
`timescale 1ns/1ps
module i2c_host_model
#(
  parameter int QTR = 8
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_sda,
  output logic      o_scl = 1'b1,
  output logic      o_sda_low = 1'b0
);
  // ==========================================================================
  // Sets the clock line and holds it a quarter bit, ending just after an edge.
  task automatic tick(input logic c);
    o_scl = c;
    repeat (QTR) @(posedge i_sys_clk);
    #1;
  endtask
  // Sends a byte most significant bit first, then releases data for the acknowledge.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 0; i < 9; i++)
    begin
      o_sda_low = (i < 8) ? !b[7 - i] : 1'b0;
      tick(1'b0);
      tick(1'b1);
      if (i == 8) ack = !i_sda;
      tick(1'b1);
      tick(1'b0);
    end
  endtask
  // Start, address, a single mode byte, stop.
  task automatic write_mode(input logic [7:0] a, input logic [7:0] d, output logic ack_a, output logic ack_d);
    o_sda_low = 1'b1;
    tick(1'b1);
    tick(1'b0);
    put_byte(a, ack_a);
    put_byte(d, ack_d);
    o_sda_low = 1'b1;
    tick(1'b0);
    tick(1'b1);
    o_sda_low = 1'b0;
    tick(1'b1);
  endtask
endmodule // i2c_host_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the sync processor control top.
`timescale 1ns/1ps
module tb_top;
  localparam int HL  = 200;
  localparam int FLY = 8000;
  logic       i_sys_clk, i_reset_n, i_scl, i_sda, sda_low, o_sda_o, o_sda_oe, o_mute, o_test_mode;
  logic       i_coinc_lock, i_noise_only, i_field_60hz, i_vsync_start, o_standard_mode, o_vflyback;
  logic       o_external_video_select, o_nil_active, o_force_nominal, o_force_625, o_phase1_gate;
  logic       o_slow_discr, o_clamp_gate, o_indirect_sync, o_hsep_gated, o_noise_inhibit, o_ident_60hz, o_vblank;
  logic [7:0] cur = 8'hff;
  logic [7:0] tbl [8] = '{8'hf0, 8'hfa, 8'h7f, 8'hd7, 8'h37, 8'hdf, 8'hef, 8'hff};
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // ==========================================================================
  // Data line has a pull-up and goes low when either party pulls it.
  assign i_sda = !(sda_low || (o_sda_oe && !o_sda_o));
  sync_ctrl #(.LINE_CYC(2 * HL), .FLYBACK_CYC(FLY)) dut
  (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe), .i_coinc_lock(i_coinc_lock), .i_noise_only(i_noise_only), .i_field_60hz(i_field_60hz),
    .i_vsync_start(i_vsync_start), .o_standard_mode(o_standard_mode),
    .o_external_video_select(o_external_video_select), .o_nil_active(o_nil_active), .o_test_mode(o_test_mode),
    .o_force_nominal(o_force_nominal), .o_force_625(o_force_625), .o_phase1_gate(o_phase1_gate),
    .o_slow_discr(o_slow_discr), .o_clamp_gate(o_clamp_gate), .o_mute(o_mute), .o_indirect_sync(o_indirect_sync),
    .o_hsep_gated(o_hsep_gated), .o_noise_inhibit(o_noise_inhibit), .o_ident_60hz(o_ident_60hz),
    .o_vblank(o_vblank), .o_vflyback(o_vflyback)
  );
  i2c_host_model host (.i_sys_clk(i_sys_clk), .i_sda(i_sda), .o_scl(i_scl), .o_sda_low(sda_low));
  // Clock with a 5 ns period.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = !i_sys_clk;
  end
  // Cuts a hung run short.
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Expected mode outputs: standard, external video, non-interlace request, test.
  function automatic logic [3:0] exp_mode(input logic [7:0] b);
    return {b[0], !b[1], !b[2], !(b[4] && (b[3] ? b[7] && b[6] : b[5]))};
  endfunction
  function automatic logic near(input int a, input int b);
    return a >= 0 && a - b <= 6 && b - a <= 6;
  endfunction
  // Writes a mode byte and checks the acknowledges and the decoded fields.
  task automatic mode(input logic [7:0] a, input logic [7:0] d, input logic ok);
    logic aa, ad;
    host.write_mode(a, d, aa, ad);
    if (ok) cur = d;
    chk({aa, ad}, {ok, ok});
    chk({o_standard_mode, o_external_video_select, o_nil_active, o_test_mode}, exp_mode(cur));
  endtask
  // Pulses vertical sync and measures blanking start, blanking and flyback length.
  task automatic blank(input logic lk, input logic f60, input int st, input int len, input int fly);
    int b0 = -1;
    int b1 = -1;
    int f0 = -1;
    int f1 = -1;
    i_coinc_lock = lk;
    i_field_60hz = f60;
    cyc(4);
    i_vsync_start = 1'b1;
    cyc(1);
    i_vsync_start = 1'b0;
    for (int t = 0; t < 12000; t++)
    begin
      if (o_vblank && b0 < 0) b0 = t;
      if (!o_vblank && b0 >= 0 && b1 < 0) b1 = t;
      if (o_vflyback && f0 < 0) f0 = t;
      if (!o_vflyback && f0 >= 0 && f1 < 0) f1 = t;
      cyc(1);
    end
    chk({near(b0, st), near(b1 - b0, len)}, 2'h3);
    chk(near(f1 - f0, fly), 1'b1);
  endtask
  // ==========================================================================
  // Main sequence.
  initial
  begin
    i_reset_n = 1'b0;
    i_coinc_lock = 1'b0;
    i_noise_only = 1'b0;
    i_field_60hz = 1'b0;
    i_vsync_start = 1'b0;
    cyc(3);
    i_reset_n = 1'b1;
    cyc(2);
    foreach (tbl[i]) mode(8'h8c, tbl[i], 1'b1);
    mode(8'h8d, 8'hf0, 1'b0);
    mode(8'h0c, 8'hf0, 1'b0);
    i_noise_only = 1'b1;
    i_field_60hz = 1'b1;
    cyc(3);
    chk({o_force_nominal, o_force_625, o_ident_60hz, o_mute}, 4'hd);
    i_noise_only = 1'b0;
    blank(1'b0, 1'b0, 3200, 45 * HL - 3200, FLY);
    blank(1'b0, 1'b1, 3200, 37 * HL - 3200, FLY);
    blank(1'b1, 1'b1, 2, 37 * HL, FLY);
    mode(8'h8c, 8'hfb, 1'b1);
    blank(1'b0, 1'b1, 3200, 37 * HL - 3200, FLY - 6400);
    i_reset_n = 1'b0;
    cyc(2);
    i_reset_n = 1'b1;
    cur = 8'hff;
    cyc(2);
    chk({o_standard_mode, o_external_video_select, o_nil_active, o_test_mode}, exp_mode(cur));
    finish_test();
  end
endmodule // tb_top
bind sync_ctrl sync_ctrl_props props
(
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .o_sda_oe(o_sda_oe), .i_coinc_lock(i_coinc_lock),
  .i_noise_only(i_noise_only), .i_field_60hz(i_field_60hz), .i_vsync_start(i_vsync_start),
  .o_standard_mode(o_standard_mode), .o_external_video_select(o_external_video_select),
  .o_nil_active(o_nil_active), .o_force_nominal(o_force_nominal), .o_force_625(o_force_625),
  .o_phase1_gate(o_phase1_gate), .o_slow_discr(o_slow_discr), .o_clamp_gate(o_clamp_gate), .o_mute(o_mute),
  .o_indirect_sync(o_indirect_sync), .o_hsep_gated(o_hsep_gated), .o_noise_inhibit(o_noise_inhibit),
  .o_ident_60hz(o_ident_60hz), .o_vblank(o_vblank)
);
